// ==== dv/gprr_host_model.sv ====
`timescale 1ns/1ns
// gprr_host_model: host side of the report stream, paces tx_ready
// assumes: the bench checks every byte; this model only accepts them
module gprr_host_model (
  // clock and reset
  input  logic clk_sys,
  input  logic reset,
  // pacing and stream
  input  logic slow,
  input  logic tx_valid,
  output logic tx_ready
);
  logic [7:0] lfsr;  // stall pattern, changes every cycle

  // take each byte at once, or stall at random while slow
  // stalls only while a byte waits, so the design must hold it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfsr     <= 8'h5d;
      tx_ready <= 1'b0;
    end else begin
      lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      tx_ready <= !slow || lfsr[0] || !tx_valid;
    end
  end
endmodule // gprr_host_model

// ==== dv/gprr_top_bench.sv ====
`timescale 1ns/1ns
// gprr_top_bench: self-checking bench of the report responder
// assumes: gprr_pkg, gprr_top and gprr_host_model compiled first
module gprr_top_bench;
  import gprr_pkg::*;
  localparam logic [7:0] IDA = 8'h3c;  // arbitrary identity value
  localparam logic [7:0] IDB = 8'h3d;  // arbitrary identity value
  localparam logic [7:0] ST2 = 8'h01;  // super packet marker
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        req_valid, state_change, fix_done, almanac_stale, sat_time_held;
  logic        tx_valid, tx_ready, tx_first, tx_last, time_accept, fix3d_ok, irq, slow;
  logic [7:0]  paddr, req_code, tx_code, tx_data;
  logic [31:0] pwdata, prdata, pdop, seed, rd;
  logic [31:0] mir [0:25];  // bench copy of the data words
  logic [3:0]  sat_count;
  logic [17:0] e;
  logic [17:0] expq [$];    // expected code, byte, first, last
  logic [7:0]  pay [$];     // payload being assembled
  int          num_errors, tests_run, ta_count, i, n;

  gprr_top #(.ID_CODE_A(IDA), .ID_CODE_B(IDB), .STATUS2(ST2)) i_gprr_top (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid, .req_code, .state_change, .fix_done,
    .almanac_stale, .sat_time_held, .sat_count, .pdop, .tx_valid, .tx_ready,
    .tx_code, .tx_data, .tx_first, .tx_last, .time_accept, .fix3d_ok, .irq);
  gprr_host_model i_gprr_host_model (.clk_sys, .reset, .slow, .tx_valid, .tx_ready);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] w, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {w, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("apb timeout", 0, 1);
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic req(input logic [7:0] c);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_code <= c;
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask

  task automatic pulse_fix();
    @(posedge clk_sys);
    fix_done <= 1'b1;
    @(posedge clk_sys);
    fix_done <= 1'b0;
  endtask

  // payload bytes of data words, most significant byte first
  task automatic add(input int w, input int nb);
    for (int j = 0; j < nb; j++) pay.push_back(mir[w + j / 4][31 - 8 * (j % 4) -: 8]);
  endtask

  task automatic commit(input logic [7:0] c);
    foreach (pay[j]) expq.push_back({c, pay[j], j == 0, j == pay.size() - 1});
    pay.delete();
  endtask

  // wait until every expected byte has gone, whole reply before the next
  task automatic drain();
    int k;
    k = 0;
    while ((expq.size() > 0 || tx_valid === 1'b1) && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000) begin
      chk("stream timeout", 0, 1);
      conclude();
    end
    repeat (3) @(posedge clk_sys);
  endtask

  // every accepted byte is matched to the oldest note; extra bytes fail
  always @(posedge clk_sys) begin
    if (!reset && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 18'h3ffff;
      chk("report byte", {tx_code, tx_data, tx_first, tx_last}, e);
    end
  end

  always @(posedge clk_sys) if (time_accept === 1'b1) ta_count++;

  initial begin
    {psel, penable, pwrite, req_valid, state_change, fix_done} = '0;
    {almanac_stale, sat_time_held, slow, paddr, req_code} = '0;
    {pwdata, pdop, sat_count} = '0;
    {num_errors, tests_run, ta_count} = '0;
    seed = 32'h34a58b6d;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    // parameter words come up at their defaults
    apb(1'b0, W_DYN, 0);
    chk("dyn reset", rd, 32'h1);
    apb(1'b0, W_ELEV, 0);
    chk("elev reset", rd, ELEV_RST);
    apb(1'b0, W_ELEV + 6'h1, 0);
    chk("sig reset", rd, SIGM_RST);
    apb(1'b0, W_PDOPM, 0);
    chk("pdop reset", rd, PDOPM_RST);
    apb(1'b0, W_PDOPM + 6'h1, 0);
    chk("switch reset", rd, PDOPS_RST);
    apb(1'b0, 6'h1a, 0);
    chk("unmapped", err, 1);
    // random data words; top bit clear keeps them positive floats
    for (i = 5; i < 26; i++) begin
      mir[i] = rnd() & 32'h7ffffff0;
      apb(1'b1, i[5:0], mir[i]);
    end
    // code 0 and codes above 4 leave the dynamics unchanged
    mir[4] = 32'h1;
    for (i = 0; i < 6; i++) begin
      apb(1'b1, W_DYN, i);
      if (i >= 1 && i <= 4) mir[4] = i;
      apb(1'b0, W_DYN, 0);
      chk("dynamics", rd, mir[4]);
    end
    pay.push_back(mir[4][7:0]);
    add(5, 16);
    commit(8'h4c);
    req(REQ_PARM);
    drain();
    // three requests back to back while the host stalls
    slow <= 1'b1;
    add(9, 4);
    commit(8'h4d);
    add(10, 26);
    commit(8'h4f);
    add(24, 4);
    commit(8'h55);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_code <= REQ_OSC;
    @(posedge clk_sys);
    req_code <= REQ_UTC;
    @(posedge clk_sys);
    req_code <= REQ_IO;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    drain();
    slow <= 1'b0;
    // time set accepted only while no satellite time is held
    for (i = 0; i < 2; i++) begin
      sat_time_held <= i[0];
      n = ta_count;
      pay.push_back(i[0] ? ACK_NO : ACK_YES);
      commit(8'h4e);
      req(REQ_TIME);
      drain();
      chk("time accept", ta_count - n, 1 - i);
    end
    // identity report for both variants, health report after it
    for (i = 0; i < 4; i++) begin
      apb(1'b1, W_CTRL, i);
      almanac_stale <= i[1] ^ i[0];
      pay.push_back(i[0] ? IDB : IDA);
      pay.push_back({4'h0, i[1] ^ i[0], 1'b0, i[1] & i[0], 1'b0});
      pay.push_back(ST2);
      commit(8'h4b);
      add(25, 2);
      commit(8'h46);
      if (i == 2) begin
        @(posedge clk_sys);
        state_change <= 1'b1;
        @(posedge clk_sys);
        state_change <= 1'b0;
      end else req(i == 1 ? REQ_ID_B : REQ_ID_A);
      drain();
    end
    // clock mode with enu velocity: bias then velocity per fix
    apb(1'b1, W_CTRL, 32'h1c);
    add(17, 12);
    commit(8'h54);
    add(20, 16);
    add(19, 4);
    commit(8'h56);
    pulse_fix();
    drain();
    add(20, 16);
    add(19, 4);
    commit(8'h56);
    req(REQ_FIX);
    drain();
    // normal mode, enu off: a fix or request 37 sends nothing
    apb(1'b1, W_CTRL, 0);
    pulse_fix();
    req(REQ_FIX);
    drain();
    // interrupt raised, cleared, and masked for bad requests
    apb(1'b1, W_ISTAT, 32'h7);
    apb(1'b1, W_IMASK, 32'h1);
    add(9, 4);
    commit(8'h4d);
    req(REQ_OSC);
    drain();
    chk("irq sent", irq, 1);
    apb(1'b1, W_ISTAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 0);
    req(8'h99);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", irq, 0);
    apb(1'b0, W_ISTAT, 0);
    chk("istat", rd, 32'h2);
    // 3-D gate: satellite count and pdop against the mask
    for (i = 0; i < 4; i++) begin
      sat_count <= (i == 1) ? 4'h3 : (i == 3) ? 4'hf : 4'h4;
      pdop <= mir[7] + (i == 2) - (i == 3);
      repeat (3) @(posedge clk_sys);
      chk("fix3d", fix3d_ok, i != 1 && i != 2);
    end
    conclude();
  end
endmodule // gprr_top_bench

// ==== inc/gprr_pkg.sv ====
// gprr_pkg: constants, kinds and layouts of the report packet responder
// assumes: one clk_sys domain, apb word registers, a byte framer downstream
package gprr_pkg;

  // report kinds, health first so it follows the ID report at once
  typedef enum {K_HLTH, K_ID, K_PARM, K_OSC, K_ACK, K_UTC, K_BIAS, K_IO, K_VEL} gprr_kind_t;
  localparam int NKIND = 9;

  // request and report codes
  localparam logic [7:0] REQ_ID_A = 8'h25, REQ_ID_B = 8'h26, REQ_PARM = 8'h2c;
  localparam logic [7:0] REQ_OSC = 8'h2d, REQ_TIME = 8'h2e, REQ_UTC = 8'h2f;
  localparam logic [7:0] REQ_IO = 8'h35, REQ_FIX = 8'h37;
  localparam logic [7:0] ACK_YES = 8'h59, ACK_NO = 8'h4e;

  // word index of each register; byte address is four times the index
  localparam logic [5:0] W_CTRL = 6'h00, W_STAT = 6'h01, W_ISTAT = 6'h02, W_IMASK = 6'h03;
  localparam logic [5:0] W_DYN = 6'h04, W_ELEV = 6'h05, W_PDOPM = 6'h07, W_OSC = 6'h09;
  localparam logic [5:0] W_UTC = 6'h0a, W_BIAS = 6'h11, W_TOF = 6'h13, W_VE = 6'h14;
  localparam logic [5:0] W_IO = 6'h18, W_HLTH = 6'h19, W_LAST = 6'h19;

  // control and status bit positions
  localparam int CTRL_VARIANT = 0, CTRL_BBTC = 1, CTRL_ENU = 2, CTRL_VMASK = 3, CTRL_CM = 4;
  localparam logic [1:0] CM_NORMAL = 2'h0;
  localparam int ST1_BBTC = 1, ST1_ALM = 3;
  localparam int IRQ_SENT = 0, IRQ_BADREQ = 1, IRQ_TSET = 2;

  // dynamics codes and other limits
  localparam logic [7:0] DYN_LAND = 8'h01, DYN_STATIC = 8'h04;
  localparam logic [3:0] MIN_SATS_3D = 4'h4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] ELEV_RST = 32'h3e32b021, SIGM_RST = 32'h40800000;
  localparam logic [31:0] PDOPM_RST = 32'h41000000, PDOPS_RST = 32'h40c00000;

  // reset contents of the data words
  function automatic logic [31:0] reg_rst(input logic [5:0] w);
    unique case (w)
      W_DYN:         return {24'h000000, DYN_LAND};
      W_ELEV:        return ELEV_RST;
      W_ELEV + 6'h1: return SIGM_RST;
      W_PDOPM:       return PDOPM_RST;
      W_PDOPM + 6'h1: return PDOPS_RST;
      default:       return 32'h00000000;
    endcase
  endfunction

  // payload length in bytes of each report
  function automatic logic [4:0] rep_len(input gprr_kind_t k);
    unique case (k)
      K_HLTH: return 5'h02;
      K_ID:   return 5'h03;
      K_PARM: return 5'h11;
      K_ACK:  return 5'h01;
      K_UTC:  return 5'h1a;
      K_BIAS: return 5'h0c;
      K_VEL:  return 5'h14;
      default: return 5'h04;
    endcase
  endfunction

  // report code of each kind
  function automatic logic [7:0] rep_code(input gprr_kind_t k);
    unique case (k)
      K_HLTH: return 8'h46;
      K_ID:   return 8'h4b;
      K_PARM: return 8'h4c;
      K_OSC:  return 8'h4d;
      K_ACK:  return 8'h4e;
      K_UTC:  return 8'h4f;
      K_BIAS: return 8'h54;
      K_IO:   return 8'h55;
      default: return 8'h56;
    endcase
  endfunction

endpackage

// ==== logic/gprr_top.sv ====
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// gprr_top: report packet responder, apb registers and a report byte stream
// assumes: requests arrive decoded from a parser on clk_sys; a framer drains tx_*
module gprr_top #(
  parameter logic [7:0] ID_CODE_A = 8'h5a,  // arbitrary identity value
  parameter logic [7:0] ID_CODE_B = 8'h5b,  // arbitrary identity value
  parameter logic [7:0] STATUS2   = 8'h01   // super packet support marker
)(
  // clock and reset
  input  logic        clk_sys,
  input  logic        reset,
  // apb slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // decoded host requests
  input  logic        req_valid,
  input  logic [7:0]  req_code,
  // receiver state
  input  logic        state_change,
  input  logic        fix_done,
  input  logic        almanac_stale,
  input  logic        sat_time_held,
  input  logic [3:0]  sat_count,
  input  logic [31:0] pdop,
  // report byte stream
  output logic        tx_valid,
  input  logic        tx_ready,
  output logic [7:0]  tx_code,
  output logic [7:0]  tx_data,
  output logic        tx_first,
  output logic        tx_last,
  // status
  output logic        time_accept,
  output logic        fix3d_ok,
  output logic        irq
);
  import gprr_pkg::*;

  logic [31:0]      regs [W_DYN:W_LAST]; // report data words
  logic [7:0]       ctrl;                // variant, clock, velocity, mode
  logic [2:0]       istat;               // sticky events
  logic [2:0]       imask;               // interrupt enables
  logic [2:0]       next_istat;          // events after clears
  logic [NKIND-1:0] pend;                // reports waiting to go
  logic [NKIND-1:0] set_p;               // new report demands
  logic [NKIND-1:0] clr_p;               // report taken for sending
  gprr_kind_t       cur_k;               // report being sent
  gprr_kind_t       pick_k;              // next report to start
  logic             busy;                // mid report
  logic [4:0]       idx;                 // next payload byte
  logic [7:0]       ack_q;               // latched acknowledgement
  logic [7:0]       st1;                 // status one byte
  logic [31:0]      rd;                  // read mux

  // one byte of a data word, most significant byte first
  function automatic logic [7:0] wb(input logic [5:0] w, input logic [1:0] s);
    logic [31:0] v;
    v = regs[w];
    return v[5'd24 - {s, 3'b000} +: 8];
  endfunction

  // payload byte i of report kind k
  function automatic logic [7:0] pay_byte(input gprr_kind_t k, input logic [4:0] i);
    logic [4:0] j;
    j = 5'(i - 5'h01);
    unique case (k)
      K_ID:   return (i == 5'h00) ? (ctrl[CTRL_VARIANT] ? ID_CODE_B : ID_CODE_A)
                   : (i == 5'h01) ? st1 : STATUS2;
      K_HLTH: return wb(W_HLTH, i[1:0]);
      K_PARM: return (i == 5'h00) ? regs[W_DYN][7:0]
                   : wb(6'(W_ELEV + {3'h0, j[4:2]}), j[1:0]);
      K_OSC:  return wb(W_OSC, i[1:0]);
      K_ACK:  return ack_q;
      K_UTC:  return wb(6'(W_UTC + {3'h0, i[4:2]}), i[1:0]);
      K_BIAS: return wb(6'(W_BIAS + {3'h0, i[4:2]}), i[1:0]);
      K_IO:   return wb(W_IO, i[1:0]);
      default: return wb((i < 5'h10) ? 6'(W_VE + {3'h0, i[4:2]}) : W_TOF, i[1:0]);
    endcase
  endfunction

  // apb decode; every transfer gets one wait state so read data comes from a flop
  wire [5:0] widx   = paddr[7:2];
  wire       hit    = (widx <= W_LAST) & (paddr[1:0] == 2'b00);
  wire       acc    = psel & penable;
  wire       wr_go  = acc & pready & pwrite & hit;
  wire       dyn_ok = (pwdata[7:0] >= DYN_LAND) & (pwdata[7:0] <= DYN_STATIC);
  wire       wr_dat = wr_go & (widx >= W_DYN) & ((widx != W_DYN) | dyn_ok);

  // request decode
  wire req_id   = req_valid & ((req_code == REQ_ID_A) | (req_code == REQ_ID_B));
  wire req_parm = req_valid & (req_code == REQ_PARM);
  wire req_osc  = req_valid & (req_code == REQ_OSC);
  wire req_time = req_valid & (req_code == REQ_TIME);
  wire req_utc  = req_valid & (req_code == REQ_UTC);
  wire req_io   = req_valid & (req_code == REQ_IO);
  wire req_fix  = req_valid & (req_code == REQ_FIX);
  wire req_bad  = req_valid & ~(req_id | req_parm | req_osc | req_time | req_utc
                                | req_io | req_fix);
  wire time_go  = req_time & ~sat_time_held;
  wire enu_sel  = ctrl[CTRL_ENU];
  wire bias_on  = ctrl[CTRL_CM +: 2] != CM_NORMAL;

  // stream control: a slot is free when nothing waits on the framer
  wire        slot      = ~tx_valid | tx_ready;
  wire        start     = ~busy & slot & (|pend);
  wire        step      = busy & slot;
  gprr_kind_t next_k;
  assign next_k = busy ? cur_k : pick_k;
  wire [4:0]  next_i    = busy ? idx : 5'h00;
  wire        next_last = next_i == 5'(rep_len(next_k) - 5'h01);
  logic [7:0] next_byte;
  // a process rather than an assign, so it also wakes on the words pay_byte reads
  always_comb begin
    next_byte = pay_byte(next_k, next_i);
  end
  wire        sent      = tx_valid & tx_ready & tx_last;

  // status one byte
  always_comb begin
    st1 = 8'h00;
    st1[ST1_BBTC] = ctrl[CTRL_VARIANT] & ctrl[CTRL_BBTC];
    st1[ST1_ALM]  = almanac_stale;
  end

  // lowest pending kind wins; health sits first so it trails its ID report
  always_comb begin
    pick_k = K_HLTH;
    for (int n = NKIND - 1; n >= 0; n--) begin
      if (pend[n]) begin
        pick_k = gprr_kind_t'(n);
      end
    end
  end

  // report demands from requests, events and the pairing of ID and health
  always_comb begin
    set_p = '0;
    clr_p = '0;
    set_p[K_ID]   = req_id | state_change;
    set_p[K_HLTH] = start & (pick_k == K_ID);
    set_p[K_PARM] = req_parm;
    set_p[K_OSC]  = req_osc;
    set_p[K_ACK]  = req_time;
    set_p[K_UTC]  = req_utc;
    set_p[K_BIAS] = fix_done & bias_on;
    set_p[K_IO]   = req_io;
    set_p[K_VEL]  = enu_sel & ((fix_done & ctrl[CTRL_VMASK]) | req_fix);
    if (start) begin
      clr_p[pick_k] = 1'b1;
    end
  end

  // interrupt events; a new event beats a write-one clear in the same cycle
  always_comb begin
    next_istat = istat;
    if (wr_go & (widx == W_ISTAT)) begin
      next_istat = istat & ~pwdata[2:0];
    end
    next_istat[IRQ_SENT]   = next_istat[IRQ_SENT] | sent;
    next_istat[IRQ_BADREQ] = next_istat[IRQ_BADREQ] | req_bad;
    next_istat[IRQ_TSET]   = next_istat[IRQ_TSET] | time_go;
  end

  // read mux
  always_comb begin
    rd = 32'h00000000;
    if (widx == W_CTRL) begin
      rd = {24'h000000, ctrl};
    end else if (widx == W_STAT) begin
      rd = {21'h000000, fix3d_ok, busy, pend};
    end else if (widx == W_ISTAT) begin
      rd = {29'h00000000, istat};
    end else if (widx == W_IMASK) begin
      rd = {29'h00000000, imask};
    end else if (hit) begin
      rd = regs[widx];
    end
  end

  // apb answer: pready rises one cycle into the access phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : rd;
        pslverr <= ~hit;
      end
    end
  end

  // control registers and the retained parameter and data words
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl  <= CTRL_RST;
      imask <= 3'h0;
      istat <= 3'h0;
      for (int n = W_DYN; n <= W_LAST; n++) begin
        regs[n] <= reg_rst(6'(n));
      end
    end else begin
      istat <= next_istat;
      if (wr_go & (widx == W_CTRL)) begin
        ctrl <= pwdata[7:0];
      end
      if (wr_go & (widx == W_IMASK)) begin
        imask <= pwdata[2:0];
      end
      // code 0 or an unknown code leaves the dynamics setting alone
      if (wr_dat) begin
        regs[widx] <= (widx == W_DYN) ? {24'h000000, pwdata[7:0]} : pwdata;
      end
    end
  end

  // pending reports and the acknowledgement byte
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend        <= '0;
      ack_q       <= ACK_NO;
      time_accept <= 1'b0;
    end else begin
      pend        <= (pend & ~clr_p) | set_p;
      time_accept <= time_go;
      if (req_time) begin
        ack_q <= sat_time_held ? ACK_NO : ACK_YES;
      end
    end
  end

  // byte sequencer; a report holds the stream until its last byte leaves
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy  <= 1'b0;
      cur_k <= K_HLTH;
      idx   <= 5'h00;
    end else if (start | step) begin
      busy  <= ~next_last;
      cur_k <= next_k;
      idx   <= 5'(next_i + 5'h01);
    end
  end

  // stream outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_code  <= 8'h00;
      tx_data  <= 8'h00;
      tx_first <= 1'b0;
      tx_last  <= 1'b0;
    end else if (start | step) begin
      tx_valid <= 1'b1;
      tx_code  <= rep_code(next_k);
      tx_data  <= next_byte;
      tx_first <= start;
      tx_last  <= next_last;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // fix gate and interrupt output; pdop is a positive single, so it orders as unsigned
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fix3d_ok <= 1'b0;
      irq      <= 1'b0;
    end else begin
      fix3d_ok <= (sat_count >= MIN_SATS_3D) & (pdop <= regs[W_PDOPM]);
      irq      <= |(next_istat & imask);
    end
  end

  // bytes accepted so far in the current report, for the checks below
  logic [4:0] acc_cnt;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_cnt <= 5'h00;
    end else if (tx_valid & tx_ready) begin
      acc_cnt <= tx_last ? 5'h00 : 5'(acc_cnt + 5'h01);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  id_on_req_a: assert property (req_id |=> pend[K_ID] | (busy & cur_k == K_ID))
    else $error("id report not queued");
  id_health_a: assert property (sent & tx_code == 8'h4b |=> tx_valid & tx_first
    & tx_code == 8'h46) else $error("health report did not follow id report");
  id_len_a: assert property (sent & tx_code == 8'h4b |-> acc_cnt == 5'h02)
    else $error("id report length wrong");
  st1_unused_a: assert property (tx_valid & tx_code == 8'h4b & acc_cnt == 5'h01
    |-> (tx_data & 8'hf5) == 8'h00) else $error("unused status bits set");
  parm_len_a: assert property (sent & tx_code == 8'h4c |-> acc_cnt == 5'h10)
    else $error("parameter report length wrong");
  dyn_keep_a: assert property (wr_go & widx == W_DYN & pwdata[7:0] == 8'h00
    |=> $stable(regs[W_DYN])) else $error("dynamics code 0 changed setting");
  fix_gate_a: assert property (fix3d_ok |-> $past(sat_count) >= 4'h4)
    else $error("3-D fix allowed with too few satellites");
  osc_len_a: assert property (sent & tx_code == 8'h4d |-> acc_cnt == 5'h03)
    else $error("oscillator report length wrong");
  ack_one_a: assert property (tx_valid & tx_code == 8'h4e |-> tx_first & tx_last)
    else $error("acknowledgement is not one byte");
  ack_yes_a: assert property (req_time & ~sat_time_held |=> time_accept
    & ack_q == ACK_YES) else $error("free time request not accepted");
  utc_len_a: assert property (sent & tx_code == 8'h4f |-> acc_cnt == 5'h19)
    else $error("utc report length wrong");
  bias_fix_a: assert property (fix_done & bias_on |=> pend[K_BIAS]
    | (busy & cur_k == K_BIAS)) else $error("bias report not queued at fix");
  vel_len_a: assert property (sent & tx_code == 8'h56 |-> acc_cnt == 5'h13)
    else $error("velocity report length wrong");
  tx_hold_a: assert property (tx_valid & ~tx_ready |=> tx_valid & $stable(tx_data)
    & $stable(tx_code)) else $error("stream byte changed while stalled");

  // payload contents seen the cycle after a byte is loaded; latched ack byte and velocity queueing the cycle after a request
  id_code_a: assert property (start & pick_k == K_ID |=> tx_first & tx_code == 8'h4b
    & (tx_data == ID_CODE_A | tx_data == ID_CODE_B)) else $error("id code byte wrong");
  id_end_a: assert property (step & cur_k == K_ID & idx == 5'h02 |=> tx_last
    & tx_data == STATUS2) else $error("status two byte wrong");
  st1_alm_a: assert property (step & cur_k == K_ID & idx == 5'h01
    |=> tx_data[ST1_ALM] == $past(almanac_stale)) else $error("almanac bit wrong");
  st1_bbtc_a: assert property (step & cur_k == K_ID & idx == 5'h01 & ~ctrl[CTRL_VARIANT]
    |=> ~tx_data[ST1_BBTC]) else $error("battery clock bit on first variant");
  parm_dyn_a: assert property (start & pick_k == K_PARM |=> tx_data >= DYN_LAND
    & tx_data <= DYN_STATIC) else $error("dynamics byte out of range");
  osc_byte_a: assert property (start & pick_k == K_OSC |=> tx_data
    == $past(regs[W_OSC][31:24])) else $error("oscillator byte wrong");
  utc_leap_a: assert property (step & cur_k == K_UTC & idx == 5'h0c |=> tx_data
    == $past(regs[W_UTC + 6'h3][31:24])) else $error("leap offset byte wrong");
  io_echo_a: assert property (start & pick_k == K_IO |=> tx_code == 8'h55
    & tx_data == $past(regs[W_IO][31:24])) else $error("option echo byte wrong");
  ack_no_a: assert property (req_time & sat_time_held |=> ~time_accept
    & ack_q == ACK_NO) else $error("held time request accepted");
  vel_req_a: assert property (req_fix & enu_sel |=> pend[K_VEL]
    | (busy & cur_k == K_VEL)) else $error("velocity report not queued");
  vel_off_a: assert property (req_fix & ~enu_sel & ~pend[K_VEL] |=> ~pend[K_VEL])
    else $error("velocity report queued with enu off");

  // report lengths and markers, and the pdop gate
  hlth_len_a: assert property (sent & tx_code == 8'h46 |-> acc_cnt == 5'h01)
    else $error("health report length wrong");
  bias_len_a: assert property (sent & tx_code == 8'h54 |-> acc_cnt == 5'h0b)
    else $error("bias report length wrong");
  io_len_a: assert property (sent & tx_code == 8'h55 |-> acc_cnt == 5'h03)
    else $error("option report length wrong");
  tx_first_a: assert property (tx_valid & tx_first |-> acc_cnt == 5'h00)
    else $error("first marker inside a report");
  fix_pdop_a: assert property (fix3d_ok |-> $past(pdop) <= $past(regs[W_PDOPM]))
    else $error("3-D fix allowed above pdop mask");

  // register bus and interrupt flags
  apb_pulse_a: assert property (pready |=> ~pready)
    else $error("pready longer than one cycle");
  apb_wait_a: assert property (psel & ~penable |=> ~pready)
    else $error("pready during setup");
  apb_err_a: assert property (acc & pready & ~hit |-> pslverr)
    else $error("unmapped access without error");
  irq_src_a: assert property (irq |-> |istat)
    else $error("interrupt without status");
  sent_flag_a: assert property (sent |=> istat[IRQ_SENT])
    else $error("sent flag not set");
  bad_flag_a: assert property (req_bad |=> istat[IRQ_BADREQ])
    else $error("bad request flag not set");

  id_pair_c: cover property (sent & tx_code == 8'h4b ##1 tx_valid & tx_code == 8'h46);
  ack_no_c: cover property (req_time & sat_time_held);
  vel_fix_c: cover property (fix_done & enu_sel & ctrl[CTRL_VMASK]);
  stall_c: cover property (tx_valid & ~tx_ready [*3]);
  bias_vel_c: cover property (sent & tx_code == 8'h54 ##1 tx_valid & tx_code == 8'h56);

endmodule // gprr_top
